// File: rtl/osrpc_ctrl.sv
// output state control with remote pin policy and apb registers
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "osrpc_defs.svh"
// Summary of operation
// - bus selector saves address and system setup
// - uart selector saves serial settings
// - bound selector saves limits and protections
// - drive selector saves drive state and mode
// - power-up drive on unless switches override
// - passive disable saves, zeroes voltage, low iprot
// - passive current mode zeroes current, low vprot
// - enable restores saved values, readable while off
// - state query returns one on, zero off
// - policy defaults high-disables, saved with bus
// - high-enables follows pin high on, low off
// - low-enables follows pin low on, high off
// - high-disables forces off while pin high
// - low-disables forces off while pin low
// - long low pulse latches off until enable
// - disabled policy ignores the pin
// - level-enable policies ignore drive commands
// - policy query reports configured policy
// - off behaviour selectable and readable
// - sampled list needs loop count one
module osrpc_ctrl
  import osrpc_pkg::*;
#(
  parameter int unsigned LPULSE_CYC = `OSRPC_LPULSE_CYC
) (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pin and front panel
  input wire logic remote_pin_in,
  input wire logic panel_on_in,
  input wire logic panel_off_in,
  // power-up setup
  input wire logic sw_out_off_in,
  input wire logic sw_analog_off_in,
  input wire logic pu_pol_vld_in,
  input wire logic [2:0] pu_pol_in,
  // analog side
  output logic drive_on_out,
  output logic analog_en_out,
  output logic [15:0] vset_out,
  output logic [15:0] iset_out,
  output logic vprot_low_out,
  output logic iprot_low_out,
  // nonvolatile store
  output logic nv_save_out,
  output logic [1:0] nv_sel_out,
  output logic [31:0] nv_data_out
);
  // ----------------------------------------
  // reset release and pin conditioner
  // ----------------------------------------
  logic [1:0] rst_sync; // two stage reset release
  logic rst_n; // released reset
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];
  osrpc_pin_if pin_if ();
  assign pin_if.pin_raw = remote_pin_in;
  osrpc_pin_cond #(.LPULSE_CYC(LPULSE_CYC)) osrpc_pin_cond_i (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .ce_in(ce_in),
    .pin(pin_if.cond)
  );
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic init; // power-up values taken
  logic drv; // drive state
  osrpc_pol_t pol; // remote pin policy
  logic [1:0] offb; // off behaviour
  logic cur; // current source mode
  logic [15:0] vprog; // programmed voltage
  logic [15:0] iprog; // programmed current
  logic [15:0] sav_v; // voltage saved at disable
  logic [15:0] sav_i; // current saved at disable
  logic [15:0] uart; // serial settings
  logic [15:0] sysset; // address and system setup
  logic [15:0] limit; // limits and protections
  logic [16:0] list; // sample flag and loop count
  logic [31:0] err; // last command error
  logic [3:0] saved; // selectors saved so far
  logic [2:0] warm; // edges since release, lets the pin filter fill
  // next values
  logic next_init;
  logic next_drv;
  osrpc_pol_t next_pol;
  logic [1:0] next_offb;
  logic next_cur;
  logic [15:0] next_vprog;
  logic [15:0] next_iprog;
  logic [15:0] next_sav_v;
  logic [15:0] next_sav_i;
  logic [15:0] next_uart;
  logic [15:0] next_sysset;
  logic [15:0] next_limit;
  logic [16:0] next_list;
  logic [31:0] next_err;
  logic [3:0] next_saved;
  logic [2:0] next_warm;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_analog;
  logic [15:0] next_vset;
  logic [15:0] next_iset;
  logic next_vprot_low;
  logic next_iprot_low;
  logic next_nv_save;
  logic [1:0] next_nv_sel;
  logic [31:0] next_nv_data;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // address hits a register
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `OSRPC_ERR);
  endfunction
  // write strobe for one register
  function automatic logic wr_hit(input logic [7:0] a,
                                  input logic [7:0] r);
    wr_hit = psel_in && penable_in && pready_out &&
             pwrite_in && (a == r);
  endfunction
  logic pin_hi;
  logic low_evt;
  logic cmd_on; // enable command from bus or panel
  logic cmd_off; // disable command from bus or panel
  logic pass_off; // passive load with drive off
  assign pin_hi = pin_if.pin_hi;
  assign low_evt = pin_if.low_evt;
  assign cmd_on = (wr_hit(paddr_in, `OSRPC_CTRL) && pwdata_in[0])
                  || panel_on_in;
  assign cmd_off = (wr_hit(paddr_in, `OSRPC_CTRL) && pwdata_in[1])
                   || panel_off_in;
  assign pass_off = !drv && (offb == `OSRPC_OB_RESIST);
  // ----------------------------------------
  // next value logic
  // ----------------------------------------
  always_comb begin
    // power-up values hold until the filter shows the real pin level,
    // so the reset level of the filter cannot force the drive off
    next_warm = {warm[1:0], 1'b1};
    next_init = warm[2];
    next_drv = drv;
    next_pol = pol;
    next_offb = offb;
    next_cur = cur;
    next_vprog = vprog;
    next_iprog = iprog;
    next_sav_v = sav_v;
    next_sav_i = sav_i;
    next_uart = uart;
    next_sysset = sysset;
    next_limit = limit;
    next_list = list;
    next_err = err;
    next_saved = saved;
    next_analog = analog_en_out;
    next_nv_save = 1'b0;
    next_nv_sel = nv_sel_out;
    next_nv_data = nv_data_out;
    // power-up: switches override the factory default
    if (!init) begin
      next_drv = !sw_out_off_in;
      next_analog = !sw_analog_off_in;
      if (pu_pol_vld_in) begin
        next_pol = osrpc_pol_t'(pu_pol_in);
      end
    end else begin
      // drive state per pin policy
      case (pol)
        POL_HEN: next_drv = pin_hi;
        POL_LEN: next_drv = !pin_hi;
        POL_HDIS: begin
          if (pin_hi) begin
            next_drv = 1'b0;
          end else if (cmd_off) begin
            next_drv = 1'b0;
          end else if (cmd_on) begin
            next_drv = 1'b1;
          end
        end
        POL_LDIS: begin
          if (!pin_hi) begin
            next_drv = 1'b0;
          end else if (cmd_off) begin
            next_drv = 1'b0;
          end else if (cmd_on) begin
            next_drv = 1'b1;
          end
        end
        POL_LPD: begin
          if (low_evt || cmd_off) begin
            next_drv = 1'b0;
          end else if (cmd_on) begin
            next_drv = 1'b1;
          end
        end
        default: begin
          // pin ignored, commands only
          if (cmd_off) begin
            next_drv = 1'b0;
          end else if (cmd_on) begin
            next_drv = 1'b1;
          end
        end
      endcase
    end
    // register writes
    if (wr_hit(paddr_in, `OSRPC_POLICY) &&
        pwdata_in[2:0] <= `OSRPC_POL_OFF) begin
      next_pol = osrpc_pol_t'(pwdata_in[2:0]);
    end
    if (wr_hit(paddr_in, `OSRPC_OFFMODE) &&
        pwdata_in[1:0] != 2'h3) begin
      next_offb = pwdata_in[1:0];
    end
    if (wr_hit(paddr_in, `OSRPC_OPMODE)) begin
      next_cur = pwdata_in[0];
    end
    if (wr_hit(paddr_in, `OSRPC_VPROG)) begin
      next_vprog = pwdata_in[15:0];
      next_sav_v = pwdata_in[15:0];
    end
    if (wr_hit(paddr_in, `OSRPC_IPROG)) begin
      next_iprog = pwdata_in[15:0];
      next_sav_i = pwdata_in[15:0];
    end
    if (wr_hit(paddr_in, `OSRPC_UART)) begin
      next_uart = pwdata_in[15:0];
    end
    if (wr_hit(paddr_in, `OSRPC_SYSSET)) begin
      next_sysset = pwdata_in[15:0];
    end
    if (wr_hit(paddr_in, `OSRPC_LIMIT)) begin
      next_limit = pwdata_in[15:0];
    end
    // software clears the error, a new error wins
    if (wr_hit(paddr_in, `OSRPC_ERR)) begin
      next_err = 32'h0;
    end
    if (wr_hit(paddr_in, `OSRPC_LIST)) begin
      if (pwdata_in[16] &&
          pwdata_in[15:0] != `OSRPC_LIST_CNT_OK) begin
        next_err = `OSRPC_ERR_CMD;
      end else begin
        next_list = pwdata_in[16:0];
      end
    end
    // disable saves programmed values, enable restores
    if (drv && !next_drv) begin
      next_sav_v = vprog;
      next_sav_i = iprog;
    end
    if (!drv && next_drv) begin
      next_vprog = sav_v;
      next_iprog = sav_i;
    end
    // save for power-up
    if (wr_hit(paddr_in, `OSRPC_SAVE)) begin
      next_nv_save = 1'b1;
      next_nv_sel = pwdata_in[1:0];
      next_saved[pwdata_in[1:0]] = 1'b1;
      case (pwdata_in[1:0])
        `OSRPC_SEL_BUS:
          next_nv_data = {13'h0, pol, sysset};
        `OSRPC_SEL_UART:
          next_nv_data = {16'h0, uart};
        `OSRPC_SEL_BOUND:
          next_nv_data = {16'h0, limit};
        default:
          next_nv_data = {30'h0, cur, drv};
      endcase
    end
  end
  // ----------------------------------------
  // apb answer and analog outputs
  // ----------------------------------------
  always_comb begin
    next_pready = psel_in && !penable_in;
    next_pslverr = psel_in && !penable_in && !mapped(paddr_in);
    next_prdata = prdata_out;
    if (psel_in && !penable_in) begin
      case (paddr_in)
        `OSRPC_CTRL: next_prdata = {31'h0, drv};
        `OSRPC_POLICY: next_prdata = {29'h0, pol};
        `OSRPC_OFFMODE: next_prdata = {30'h0, offb};
        `OSRPC_OPMODE: next_prdata = {31'h0, cur};
        `OSRPC_VPROG: next_prdata = {16'h0, sav_v};
        `OSRPC_IPROG: next_prdata = {16'h0, sav_i};
        `OSRPC_SAVE: next_prdata = {28'h0, saved};
        `OSRPC_UART: next_prdata = {16'h0, uart};
        `OSRPC_SYSSET: next_prdata = {16'h0, sysset};
        `OSRPC_LIMIT: next_prdata = {16'h0, limit};
        `OSRPC_LIST: next_prdata = {15'h0, list};
        `OSRPC_ERR: next_prdata = err;
        default: next_prdata = 32'h0;
      endcase
    end
    // passive load off: zero the main channel, low protect
    next_vset = (pass_off && !cur) ? 16'h0 : vprog;
    next_iprot_low = pass_off && !cur;
    next_iset = (pass_off && cur) ? 16'h0 : iprog;
    next_vprot_low = pass_off && cur;
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      init <= 1'b0;
      drv <= 1'b0;
      pol <= POL_HDIS;
      offb <= `OSRPC_OB_RESIST;
      cur <= 1'b0;
      vprog <= 16'h0;
      iprog <= 16'h0;
      sav_v <= 16'h0;
      sav_i <= 16'h0;
      uart <= 16'h0;
      sysset <= 16'h0;
      limit <= 16'h0;
      list <= 17'h0;
      err <= 32'h0;
      saved <= 4'h0;
      warm <= 3'h0;
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      analog_en_out <= 1'b0;
      vset_out <= 16'h0;
      iset_out <= 16'h0;
      vprot_low_out <= 1'b0;
      iprot_low_out <= 1'b0;
      nv_save_out <= 1'b0;
      nv_sel_out <= 2'h0;
      nv_data_out <= 32'h0;
    end else if (ce_in) begin
      init <= next_init;
      drv <= next_drv;
      pol <= next_pol;
      offb <= next_offb;
      cur <= next_cur;
      vprog <= next_vprog;
      iprog <= next_iprog;
      sav_v <= next_sav_v;
      sav_i <= next_sav_i;
      uart <= next_uart;
      sysset <= next_sysset;
      limit <= next_limit;
      list <= next_list;
      err <= next_err;
      saved <= next_saved;
      warm <= next_warm;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      analog_en_out <= next_analog;
      vset_out <= next_vset;
      iset_out <= next_iset;
      vprot_low_out <= next_vprot_low;
      iprot_low_out <= next_iprot_low;
      nv_save_out <= next_nv_save;
      nv_sel_out <= next_nv_sel;
      nv_data_out <= next_nv_data;
    end
  end
  assign drive_on_out = drv;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_hen_level: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && pol == POL_HEN |=> drv == $past(pin_hi))
    else $error("high-enables did not follow pin");
  a_len_level: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && pol == POL_LEN |=> drv != $past(pin_hi))
    else $error("low-enables did not follow pin");
  a_hdis_force: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && pol == POL_HDIS && pin_hi |=> !drv)
    else $error("high pin did not force off");
  a_ldis_force: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && pol == POL_LDIS && !pin_hi |=> !drv)
    else $error("low pin did not force off");
  a_lpd_latch_off: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && pol == POL_LPD && low_evt |=> !drv)
    else $error("long low pulse did not turn off");
  a_pin_ignored: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && pol == POL_OFF && !cmd_on && !cmd_off
    && !$changed(pol) |=> $stable(drv))
    else $error("disabled policy reacted to pin");
  a_state_query: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && psel_in && !penable_in && paddr_in == `OSRPC_CTRL
    |=> prdata_out == {31'h0, $past(drv)})
    else $error("state query wrong");
  a_list_error: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && wr_hit(paddr_in, `OSRPC_LIST) && pwdata_in[16]
    && pwdata_in[15:0] != `OSRPC_LIST_CNT_OK
    |=> err == `OSRPC_ERR_CMD && $stable(list))
    else $error("bad list count not flagged");
  a_off_zero_volt: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && pass_off && !cur |=> vset_out == 16'h0 && iprot_low_out)
    else $error("passive off did not zero voltage");
  a_restore_on: assert property (
    @(posedge mclk_in) disable iff (!rst_n)
    ce_in && init && !drv ##1 drv |-> vprog == $past(sav_v))
    else $error("enable did not restore voltage");
  c_hen_on: cover property (
    @(posedge mclk_in) disable iff (!rst_n)
    pol == POL_HEN && !drv ##1 drv);
  c_lpd_off: cover property (
    @(posedge mclk_in) disable iff (!rst_n) pol == POL_LPD && low_evt);
  c_save: cover property (
    @(posedge mclk_in) disable iff (!rst_n) nv_save_out);
endmodule

// File: rtl/osrpc_defs.svh
// constants for the output state and remote pin control block
`ifndef OSRPC_DEFS_SVH
`define OSRPC_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OSRPC_CTRL 8'h00
`define OSRPC_POLICY 8'h04
`define OSRPC_OFFMODE 8'h08
`define OSRPC_OPMODE 8'h0C
`define OSRPC_VPROG 8'h10
`define OSRPC_IPROG 8'h14
`define OSRPC_SAVE 8'h18
`define OSRPC_UART 8'h1C
`define OSRPC_SYSSET 8'h20
`define OSRPC_LIMIT 8'h24
`define OSRPC_LIST 8'h28
`define OSRPC_ERR 8'h2C
// ----------------------------------------
// field codes and reset values
// ----------------------------------------
`define OSRPC_POL_HEN 3'h0
`define OSRPC_POL_LEN 3'h1
`define OSRPC_POL_HDIS 3'h2
`define OSRPC_POL_LDIS 3'h3
`define OSRPC_POL_LPD 3'h4
`define OSRPC_POL_OFF 3'h5
`define OSRPC_OB_ACTIVE 2'h0
`define OSRPC_OB_RESIST 2'h1
`define OSRPC_OB_BATT 2'h2
`define OSRPC_SEL_BUS 2'h0
`define OSRPC_SEL_UART 2'h1
`define OSRPC_SEL_BOUND 2'h2
`define OSRPC_SEL_DRIVE 2'h3
`define OSRPC_ERR_CMD 32'hFFFFFF9C
`define OSRPC_LIST_CNT_OK 16'h0001
// ----------------------------------------
// timing
// ----------------------------------------
`define OSRPC_CLK_NS 5
`define OSRPC_LPULSE_NS 100000
`define OSRPC_LPULSE_CYC ((`OSRPC_LPULSE_NS+`OSRPC_CLK_NS-1)/`OSRPC_CLK_NS)
`endif

// File: rtl/osrpc_pin_cond.sv
// remote pin synchroniser, filter and low pulse width detector
`timescale 1ns/10ps
`include "osrpc_defs.svh"
module osrpc_pin_cond
  import osrpc_pkg::*;
#(
  parameter int unsigned LPULSE_CYC = `OSRPC_LPULSE_CYC
) (
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // pin side
  osrpc_pin_if.cond pin
);
  logic [2:0] sync; // three stage synchroniser
  logic pin_hi; // agreed level
  logic [31:0] cnt; // low width counter
  osrpc_lp_t st;
  logic [2:0] next_sync;
  logic next_pin_hi;
  logic [31:0] next_cnt;
  osrpc_lp_t next_st;
  logic next_evt;
  logic evt;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_sync = {sync[1:0], pin.pin_raw};
    next_pin_hi = pin_hi;
    // change counts once stages two and three agree
    if (sync[1] == sync[2]) begin
      next_pin_hi = sync[2];
    end
    next_cnt = cnt;
    next_st = st;
    next_evt = 1'b0;
    case (st)
      LP_IDLE: begin
        next_cnt = 32'h0;
        if (!pin_hi) begin
          next_st = LP_CNT;
        end
      end
      LP_CNT: begin
        if (pin_hi) begin
          next_st = LP_IDLE; // too short, forget it
        end else if (cnt >= LPULSE_CYC - 2) begin
          next_evt = 1'b1;
          next_st = LP_DONE;
        end else begin
          next_cnt = cnt + 32'h1;
        end
      end
      LP_DONE: begin
        if (pin_hi) begin
          next_st = LP_IDLE;
        end
      end
      default: next_st = LP_IDLE;
    endcase
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync <= 3'h7;
      pin_hi <= 1'b1;
      cnt <= 32'h0;
      st <= LP_IDLE;
      evt <= 1'b0;
    end else if (ce_in) begin
      sync <= next_sync;
      pin_hi <= next_pin_hi;
      cnt <= next_cnt;
      st <= next_st;
      evt <= next_evt;
    end
  end
  assign pin.pin_hi = pin_hi;
  assign pin.low_evt = evt;
  // event only after a low that lasted the full count
  // the level may rise at the very edge that raises the event
  a_evt_after_low: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(evt) |-> !$past(pin_hi) && cnt >= LPULSE_CYC - 2)
    else $error("low event without full low width");
endmodule

// File: rtl/osrpc_pin_if.sv
// conditioned remote pin signals between the control and the conditioner
`timescale 1ns/10ps
interface osrpc_pin_if;
  logic pin_raw; // unsynchronised pin level
  logic pin_hi; // filtered level
  logic low_evt; // low held long enough, one pulse
  modport cond (input pin_raw, output pin_hi, output low_evt);
  modport user (output pin_raw, input pin_hi, input low_evt);
endinterface

// File: rtl/osrpc_pkg.sv
// types for the output state and remote pin control block
`include "osrpc_defs.svh"
package osrpc_pkg;
  // remote pin policy field
  typedef enum logic [2:0] {
    POL_HEN = `OSRPC_POL_HEN,
    POL_LEN = `OSRPC_POL_LEN,
    POL_HDIS = `OSRPC_POL_HDIS,
    POL_LDIS = `OSRPC_POL_LDIS,
    POL_LPD = `OSRPC_POL_LPD,
    POL_OFF = `OSRPC_POL_OFF
  } osrpc_pol_t;
  // low pulse detector states
  typedef enum logic [2:0] {
    LP_IDLE = 3'b001,
    LP_CNT = 3'b010,
    LP_DONE = 3'b100
  } osrpc_lp_t;
endpackage

// File: tb/osrpc_ctrl_bench.sv
// self-checking bench for the output state and remote pin control
`timescale 1ns/10ps
`include "osrpc_defs.svh"
module osrpc_ctrl_bench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd, nvd;
  logic prdy, perr, pin, drv, ana, vpl, ipl, nvs;
  logic p_open = 1'b0, p_lvl = 1'b0, pon = 1'b0, poff = 1'b0, ce = 1'b1;
  logic [15:0] vset, iset;
  logic [1:0] nvsel;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  // clock at 200 MHz
  initial begin
    forever #2.5 clk = ~clk;
  end
  osrpc_pin_drv osrpc_pin_drv_i (.open_in(p_open), .lvl_in(p_lvl),
    .pin_out(pin));
  osrpc_ctrl #(.LPULSE_CYC(20)) osrpc_ctrl_i (.mclk_in(clk),
    .rst_b_in(rst_b), .ce_in(ce), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .remote_pin_in(pin),
    .panel_on_in(pon), .panel_off_in(poff), .sw_out_off_in(1'b0),
    .sw_analog_off_in(1'b0), .pu_pol_vld_in(1'b0), .pu_pol_in(3'h0),
    .drive_on_out(drv), .analog_en_out(ana), .vset_out(vset),
    .iset_out(iset), .vprot_low_out(vpl), .iprot_low_out(ipl),
    .nv_save_out(nvs), .nv_sel_out(nvsel), .nv_data_out(nvd));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // wait for the answer; only the bench limit ends a hang
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0; pen <= 1'b0;
    // one idle edge so a following call never rewrites psel at once
    @(posedge clk);
  endtask
  // move the contact, then let filter and drive settle
  task automatic pin_set(input logic o, l);
    p_open <= o; p_lvl <= l;
    repeat (8) @(posedge clk);
  endtask
  task automatic pol(input logic [2:0] p);
    apb(1'b1, `OSRPC_POLICY, {29'h0, p});
    apb(1'b0, `OSRPC_POLICY, 32'h0);
    chk("policy", rd, {29'h0, p});
  endtask
  task automatic ctl(input logic [31:0] c, input logic e);
    apb(1'b1, `OSRPC_CTRL, c);
    repeat (3) @(posedge clk);
    chk("drive", drv, e);
  endtask
  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_hdis;
    apb(1'b1, `OSRPC_VPROG, 32'h1234);
    pin_set(1'b1, 1'b1);
    chk("drive", drv, 1'b0);
    chk("vset", vset, 16'h0);
    chk("iprot", ipl, 1'b1);
    apb(1'b0, `OSRPC_VPROG, 32'h0);
    chk("vsaved", rd, 32'h1234);
    apb(1'b0, `OSRPC_CTRL, 32'h0);
    chk("state", rd, 32'h0);
    pin_set(1'b0, 1'b0);
    chk("drive", drv, 1'b0);
    pon <= 1'b1;
    @(posedge clk);
    pon <= 1'b0;
    repeat (3) @(posedge clk);
    chk("drive", drv, 1'b1);
    chk("vset", vset, 16'h1234);
  endtask
  task automatic t_cur;
    apb(1'b1, `OSRPC_IPROG, 32'h0055);
    apb(1'b1, `OSRPC_OPMODE, 32'h1);
    ctl(32'h2, 1'b0);
    chk("iset", iset, 16'h0);
    chk("vprot", vpl, 1'b1);
    ctl(32'h1, 1'b1);
    chk("iset", iset, 16'h0055);
    apb(1'b1, `OSRPC_OPMODE, 32'h0);
  endtask
  task automatic t_regs;
    // bus {policy high-disables, setup}, uart, bounds, {mode, drive on}
    logic [31:0] nv_exp [4] = '{32'h0002_1111, 32'h2222, 32'h3333, 32'h1};
    apb(1'b1, `OSRPC_SYSSET, 32'h1111);
    apb(1'b1, `OSRPC_UART, 32'h2222);
    apb(1'b1, `OSRPC_LIMIT, 32'h3333);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `OSRPC_SAVE, s);
      for (int n = 0; n < 4 && nvs !== 1'b1; n++) @(posedge clk);
      chk("nvsave", nvs, 1'b1);
      chk("nvsel", nvsel, s);
      chk("nvdata", nvd, nv_exp[s]);
    end
    apb(1'b0, `OSRPC_SAVE, 32'h0);
    chk("saved", rd, 32'hF);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `OSRPC_OFFMODE, m);
      apb(1'b0, `OSRPC_OFFMODE, 32'h0);
      chk("offmode", rd, (m == 3) ? 32'h2 : m);
    end
    apb(1'b1, `OSRPC_OFFMODE, 32'h1);
    apb(1'b1, `OSRPC_LIST, 32'h0001_0002);
    apb(1'b0, `OSRPC_ERR, 32'h0);
    chk("err", rd, `OSRPC_ERR_CMD);
    apb(1'b1, `OSRPC_ERR, 32'h0);
    apb(1'b1, `OSRPC_LIST, 32'h0001_0001);
    apb(1'b0, `OSRPC_ERR, 32'h0);
    chk("err", rd, 32'h0);
    apb(1'b0, `OSRPC_LIST, 32'h0);
    chk("list", rd, 32'h0001_0001);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", er, 1'b1);
  endtask
  task automatic t_pols;
    pol(`OSRPC_POL_HEN);
    pin_set(1'b1, 1'b1);
    chk("drive", drv, 1'b1);
    ctl(32'h2, 1'b1);
    pin_set(1'b0, 1'b0);
    chk("drive", drv, 1'b0);
    ctl(32'h1, 1'b0);
    pol(`OSRPC_POL_LEN);
    pin_set(1'b0, 1'b0);
    chk("drive", drv, 1'b1);
    poff <= 1'b1;
    @(posedge clk);
    poff <= 1'b0;
    repeat (3) @(posedge clk);
    chk("drive", drv, 1'b1);
    pin_set(1'b1, 1'b1);
    chk("drive", drv, 1'b0);
    pol(`OSRPC_POL_LDIS);
    ctl(32'h1, 1'b1);
    pin_set(1'b0, 1'b0);
    ctl(32'h1, 1'b0);
    pin_set(1'b1, 1'b1);
    ctl(32'h1, 1'b1);
    pol(`OSRPC_POL_LPD);
    p_lvl <= 1'b0; p_open <= 1'b0;
    repeat (10) @(posedge clk);
    pin_set(1'b1, 1'b1);
    chk("drive", drv, 1'b1);
    p_lvl <= 1'b0; p_open <= 1'b0;
    repeat (40) @(posedge clk);
    pin_set(1'b1, 1'b1);
    chk("drive", drv, 1'b0);
    ctl(32'h1, 1'b1);
    pol(`OSRPC_POL_OFF);
    pin_set(1'b0, 1'b0);
    chk("drive", drv, 1'b1);
    // enable low freezes the block: a panel disable is not seen
    ce <= 1'b0;
    poff <= 1'b1;
    @(posedge clk);
    poff <= 1'b0;
    repeat (3) @(posedge clk);
    chk("frozen", drv, 1'b1);
    ce <= 1'b1;
  endtask
  // ----------------------------------------
  // run and limit
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk("drive", drv, 1'b1);
    chk("analog", ana, 1'b1);
    apb(1'b0, `OSRPC_CTRL, 32'h0);
    chk("state", rd, 32'h1);
    apb(1'b0, `OSRPC_POLICY, 32'h0);
    chk("policy", rd, 32'h2);
    apb(1'b0, `OSRPC_OFFMODE, 32'h0);
    chk("offmode", rd, 32'h1);
    t_hdis;
    t_cur;
    t_regs;
    t_pols;
    close_out;
  end
endmodule

// File: tb/osrpc_pin_drv.sv
// remote contact model driving the on/off pin of the block
`timescale 1ns/10ps
module osrpc_pin_drv (
  // contact control from the bench
  input wire logic open_in,
  input wire logic lvl_in,
  // pin towards the block
  output logic pin_out
);
  // ----------------------------------------
  // contact behaviour
  // ----------------------------------------
  // an open contact floats to the pull-up level, else the applied level
  assign pin_out = open_in ? 1'b1 : lvl_in;
endmodule
